// ---- inc/cal_regs_pkg.sv ----
package cal_regs_pkg;
    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_COMP_A = 8'h85;
    localparam logic [7:0] ADDR_COMP_B = 8'h86;
    localparam logic [7:0] ADDR_COMP_C = 8'h87;
    localparam logic [7:0] ADDR_CREEP = 8'h88;
    localparam logic [7:0] ADDR_CREEP2 = 8'h89;
    localparam logic [7:0] ADDR_REV_RMS = 8'h8a;
    localparam logic [7:0] ADDR_QUICK = 8'h8b;
    localparam logic [7:0] ADDR_PEAK = 8'h8c;
    localparam logic [7:0] ADDR_NCMP = 8'h8d;
    localparam logic [7:0] ADDR_SAG_ZX = 8'h8e;
    localparam logic [7:0] ADDR_SAG_LC = 8'h8f;
    localparam logic [7:0] ADDR_NPHCAL = 8'h90;
    localparam logic [7:0] ADDR_SGAIN = 8'h91;
    localparam logic [7:0] ADDR_SOFS = 8'h92;
    localparam logic [7:0] ADDR_SHDN = 8'h93;
    localparam logic [7:0] ADDR_RSVD = 8'h94;
    localparam logic [7:0] ADDR_USER_MODE_SELECT_1 = 8'h96;
    localparam logic [7:0] ADDR_USER_MODE_SELECT_2 = 8'h97;
    localparam logic [7:0] ADDR_USER_MODE_SELECT_3 = 8'h98;
    localparam logic [7:0] ADDR_INTERRUPT_MASK_FIRST = 8'h9a;
    localparam logic [7:0] ADDR_STATUS = 8'h99;
    localparam logic [7:0] ADDR_SOFTRST = 8'h9f;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [23:0] RST_ZERO = 24'h00_0000;
    localparam logic [23:0] RST_CREEP = 24'h04_c04c;
    localparam logic [23:0] RST_REV_RMS = 24'h04_c200;
    localparam logic [23:0] RST_QUICK = 24'h20_ffff;
    localparam logic [23:0] RST_ONES = 24'hff_ffff;
    localparam logic [23:0] RST_SAG_ZX = 24'h04_ffff;
    localparam logic [23:0] RST_SAG_LC = 24'h10_0009;
    localparam logic [23:0] RST_RSVD = 24'h00_07ff;
    // soft reset keys
    localparam logic [23:0] KEY_MEAS = 24'h5a_5a5a;
    localparam logic [23:0] KEY_CAL = 24'h55_aa55;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int HI_LSB = 12;
    localparam int SAGCNT_LSB = 16;
    localparam int USER_MODE_SELECT_3_NSEL = 4;
    localparam int GAIN_W = 16;
    localparam int SHDN_W = 11;
    localparam int RSVD_W = 16;
    localparam logic [SHDN_W-1:0] SHDN_MASK = 11'h7_3c;
    // status bit positions (sticky)
    localparam int ST_NCMP = 0;
    localparam int ST_SAG = 1;
    localparam int ST_ZXTO = 2;
    localparam int ST_W = 3;
endpackage

// ---- core/metering_threshold_calibration_regs.sv ----
`timescale 1ns/1ps
// Summary of operation
// - neutral flag is 0 when neutral rms below threshold, else 1
// - user mode 3 bit 4 picks summed-current rms or measured neutral rms
// - sag interrupt when voltage stays below sag threshold longer than sag period
// - sag period count sits in bits 23:16, resets to 04h
// - zero-cross timeout interrupt when no crossing within bits 15:0 count
// - line cycle count in bits 11:0; value plus one is cycles
// - each set shutdown bit powers down one channel converter
// - quick rms: bits 23:21 refresh period, bits 20:0 threshold
// - peak register: current threshold 23:12, voltage threshold 11:0, resets ones
// - anti-creep register: reactive 23:12, active 11:0, resets 04c04c
// - combined anti-creep register: reactive 23:12, active 11:0, resets zero
// - reverse power threshold 23:12, rms small-signal threshold 11:0, resets 04c200
// - first mask gates each interrupt source onto first request output
// - per-phase reactive compensation values are 12-bit two's complement
// - 24-bit neutral phase calibration applied to neutral channel
// - summed rms path uses 16-bit gain and 24-bit offset
// - key 5a5a5a resets measurements, key 55aa55 resets calibration bank
module metering_threshold_calibration_regs
    import cal_regs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [23:0] reg_rdata_ff,
    // metering datapath inputs, same clock
    input wire logic [23:0] summed_current_rms,
    input wire logic [23:0] neutral_current_rms,
    input wire logic [11:0] voltage_abs,
    input wire logic line_cycle_tick,
    input wire logic zero_cross,
    input wire logic sample_tick,
    // settings toward datapath
    output logic [11:0] comp_a_ff,
    output logic [11:0] comp_b_ff,
    output logic [11:0] comp_c_ff,
    output logic [23:0] creep_ff,
    output logic [23:0] creep2_ff,
    output logic [23:0] rev_rms_ff,
    output logic [23:0] quick_rms_ff,
    output logic [23:0] peak_ff,
    output logic [11:0] line_cycle_count_ff,
    output logic [23:0] neutral_phase_calibration_ff,
    output logic [GAIN_W-1:0] summed_current_rms_gain_ff,
    output logic [23:0] summed_current_rms_offset_ff,
    output logic [SHDN_W-1:0] channel_converter_shutdown_ff,
    output logic [23:0] user_mode_select_1_ff,
    output logic [23:0] user_mode_select_2_ff,
    output logic [23:0] user_mode_select_3_ff,
    output logic measure_reset_ff,
    // status and interrupt
    output logic neutral_compare_flag_ff,
    output logic interrupt_request_first_ff
);

    // ---------------------------------------------------------------
    // local state
    // ---------------------------------------------------------------
    // settings kept inside the block
    logic [23:0] ncmp_ff;
    logic [23:0] sag_zx_ff;
    logic [11:0] sag_threshold_ff;
    logic [23:0] interrupt_mask_first_ff;

    // sticky interrupt bits
    logic [ST_W-1:0] status_ff;

    // sag timer
    logic [7:0] sag_run_ff;
    logic sag_done_ff;

    // zero-cross timer
    logic [15:0] zx_cnt_ff;
    logic zx_done_ff;

    // combinational helpers
    logic cal_clear;
    logic [23:0] nrms_sel;
    logic sag_event;
    logic zx_event;
    logic [ST_W-1:0] events;
    // shared decodes, named once
    logic wr_softrst;
    logic status_rd;
    logic sag_restart;
    logic sag_due;
    logic zx_due;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // address match for writes, reads and keys
    function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
        return a == want;
    endfunction

    // a key counts only as a full word
    function automatic logic key_hit(input logic [23:0] d, input logic [23:0] key);
        return d == key;
    endfunction

    // soft reset address keeps nothing; only keys act
    assign wr_softrst = reg_wr && hit(reg_addr, ADDR_SOFTRST);

    // status read doubles as the clear strobe
    assign status_rd = reg_rd && hit(reg_addr, ADDR_STATUS);

    // bank reset: pin reset or calibration key
    // measurement key leaves this bank alone
    assign cal_clear = wr_softrst && key_hit(reg_wdata, KEY_CAL);

    // ---------------------------------------------------------------
    // calibration registers
    // ---------------------------------------------------------------
    // all writable settings; reserved address has no storage at all
    // calibration key acts like a pin reset here
    // writes land the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_b || cal_clear) begin
            comp_a_ff <= RST_ZERO[11:0];
            comp_b_ff <= RST_ZERO[11:0];
            comp_c_ff <= RST_ZERO[11:0];
            creep_ff <= RST_CREEP;
            creep2_ff <= RST_ZERO;
            rev_rms_ff <= RST_REV_RMS;
            quick_rms_ff <= RST_QUICK;
            peak_ff <= RST_ONES;
            ncmp_ff <= RST_ONES;
            sag_zx_ff <= RST_SAG_ZX;
            sag_threshold_ff <= RST_SAG_LC[23:HI_LSB];
            line_cycle_count_ff <= RST_SAG_LC[11:0];
            neutral_phase_calibration_ff <= RST_ZERO;
            summed_current_rms_gain_ff <= RST_ZERO[GAIN_W-1:0];
            summed_current_rms_offset_ff <= RST_ZERO;
            channel_converter_shutdown_ff <= RST_ZERO[SHDN_W-1:0];
            user_mode_select_1_ff <= RST_ZERO;
            user_mode_select_2_ff <= RST_ZERO;
            user_mode_select_3_ff <= RST_ZERO;
            interrupt_mask_first_ff <= RST_ZERO;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_COMP_A: comp_a_ff <= reg_wdata[11:0];
                ADDR_COMP_B: comp_b_ff <= reg_wdata[11:0];
                ADDR_COMP_C: comp_c_ff <= reg_wdata[11:0];
                ADDR_CREEP: creep_ff <= reg_wdata;
                ADDR_CREEP2: creep2_ff <= reg_wdata;
                ADDR_REV_RMS: rev_rms_ff <= reg_wdata;
                ADDR_QUICK: quick_rms_ff <= reg_wdata;
                ADDR_PEAK: peak_ff <= reg_wdata;
                ADDR_NCMP: ncmp_ff <= reg_wdata;
                ADDR_SAG_ZX: sag_zx_ff <= reg_wdata;
                // two 12-bit fields share one word
                ADDR_SAG_LC: begin
                    sag_threshold_ff <= reg_wdata[23:HI_LSB];
                    line_cycle_count_ff <= reg_wdata[11:0];
                end
                ADDR_NPHCAL: neutral_phase_calibration_ff <= reg_wdata;
                ADDR_SGAIN: summed_current_rms_gain_ff <= reg_wdata[GAIN_W-1:0];
                ADDR_SOFS: summed_current_rms_offset_ff <= reg_wdata;
                // only the seven documented channel bits are kept
                ADDR_SHDN: channel_converter_shutdown_ff <= reg_wdata[SHDN_W-1:0] & SHDN_MASK;
                ADDR_USER_MODE_SELECT_1: user_mode_select_1_ff <= reg_wdata;
                ADDR_USER_MODE_SELECT_2: user_mode_select_2_ff <= reg_wdata;
                ADDR_USER_MODE_SELECT_3: user_mode_select_3_ff <= reg_wdata;
                ADDR_INTERRUPT_MASK_FIRST: interrupt_mask_first_ff <= reg_wdata;
                // reserved, status and key addresses keep nothing
                default: ;
            endcase
        end
    end

    // measured-parameter reset request, one cycle
    // those registers live in the datapath; only the request leaves
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            measure_reset_ff <= 1'b0;
        end else begin
            measure_reset_ff <= wr_softrst && key_hit(reg_wdata, KEY_MEAS);
        end
    end

    // ---------------------------------------------------------------
    // neutral comparison
    // ---------------------------------------------------------------
    // source picked by user mode 3
    assign nrms_sel = user_mode_select_3_ff[USER_MODE_SELECT_3_NSEL] ? neutral_current_rms : summed_current_rms;

    // unsigned compare; equal is not below, so the flag sets
    // flag lags the rms inputs by one cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            neutral_compare_flag_ff <= 1'b0;
        end else begin
            neutral_compare_flag_ff <= !(nrms_sel < ncmp_ff);
        end
    end

    // ---------------------------------------------------------------
    // sag detection
    // ---------------------------------------------------------------
    // single samples decide; no filter, so noise restarts a run
    assign sag_restart = sample_tick && voltage_abs >= sag_threshold_ff;
    // run has lasted the programmed line cycles
    assign sag_due = sag_run_ff >= sag_zx_ff[23:SAGCNT_LSB];

    // counts line cycles spent below threshold; a sample above restarts it
    // resolution is one line cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sag_run_ff <= 8'h00;
            sag_done_ff <= 1'b0;
        end else if (sag_restart) begin
            sag_run_ff <= 8'h00;
            sag_done_ff <= 1'b0;
        end else if (line_cycle_tick && !sag_done_ff) begin
            if (sag_due) begin
                sag_done_ff <= 1'b1;
            end else begin
                sag_run_ff <= sag_run_ff + 8'h01;
            end
        end
    end
    // one event per sag, rising edge of done
    assign sag_event = line_cycle_tick && !sag_done_ff && !sag_restart && sag_due;

    // ---------------------------------------------------------------
    // zero-cross timeout
    // ---------------------------------------------------------------
    // count reached the programmed timeout
    assign zx_due = zx_cnt_ff >= sag_zx_ff[15:0];

    // timed in sample ticks; fires once until the next crossing
    // a timeout of zero fires on the first sample
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            zx_cnt_ff <= 16'h0000;
            zx_done_ff <= 1'b0;
        end else if (zero_cross) begin
            zx_cnt_ff <= 16'h0000;
            zx_done_ff <= 1'b0;
        end else if (sample_tick && !zx_done_ff) begin
            if (zx_due) begin
                zx_done_ff <= 1'b1;
            end else begin
                zx_cnt_ff <= zx_cnt_ff + 16'h0001;
            end
        end
    end
    assign zx_event = !zero_cross && sample_tick && !zx_done_ff && zx_due;

    // ---------------------------------------------------------------
    // interrupt status and request
    // ---------------------------------------------------------------
    // neutral flag is a level; it re-sets status while high
    always_comb begin
        events = '0;
        events[ST_NCMP] = neutral_compare_flag_ff;
        events[ST_SAG] = sag_event;
        events[ST_ZXTO] = zx_event;
    end

    // read clears, but a same-cycle event wins
    // the read returns the bits from before the clear
    always_ff @(posedge clk) begin
        if (!rst_b || cal_clear) begin
            status_ff <= '0;
        end else if (status_rd) begin
            status_ff <= events;
        end else begin
            status_ff <= status_ff | events;
        end
    end

    // level request while any unmasked sticky bit is set
    // upper mask bits are stored but have no source yet
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            interrupt_request_first_ff <= 1'b0;
        end else begin
            interrupt_request_first_ff <= |(status_ff & interrupt_mask_first_ff[ST_W-1:0]);
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    // unmapped addresses read zero; data valid from the cycle after
    // narrow registers read zero in unused upper bits
    // data holds until the next read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata_ff <= RST_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_COMP_A: reg_rdata_ff <= {12'h000, comp_a_ff};
                ADDR_COMP_B: reg_rdata_ff <= {12'h000, comp_b_ff};
                ADDR_COMP_C: reg_rdata_ff <= {12'h000, comp_c_ff};
                ADDR_CREEP: reg_rdata_ff <= creep_ff;
                ADDR_CREEP2: reg_rdata_ff <= creep2_ff;
                ADDR_REV_RMS: reg_rdata_ff <= rev_rms_ff;
                ADDR_QUICK: reg_rdata_ff <= quick_rms_ff;
                ADDR_PEAK: reg_rdata_ff <= peak_ff;
                ADDR_NCMP: reg_rdata_ff <= ncmp_ff;
                ADDR_SAG_ZX: reg_rdata_ff <= sag_zx_ff;
                ADDR_SAG_LC: reg_rdata_ff <= {sag_threshold_ff, line_cycle_count_ff};
                ADDR_NPHCAL: reg_rdata_ff <= neutral_phase_calibration_ff;
                ADDR_SGAIN: reg_rdata_ff <= {8'h00, summed_current_rms_gain_ff};
                ADDR_SOFS: reg_rdata_ff <= summed_current_rms_offset_ff;
                ADDR_SHDN: reg_rdata_ff <= {13'h0000, channel_converter_shutdown_ff};
                ADDR_RSVD: reg_rdata_ff <= RST_RSVD;
                ADDR_USER_MODE_SELECT_1: reg_rdata_ff <= user_mode_select_1_ff;
                ADDR_USER_MODE_SELECT_2: reg_rdata_ff <= user_mode_select_2_ff;
                ADDR_USER_MODE_SELECT_3: reg_rdata_ff <= user_mode_select_3_ff;
                ADDR_STATUS: reg_rdata_ff <= {21'h00_0000, status_ff};
                ADDR_INTERRUPT_MASK_FIRST: reg_rdata_ff <= interrupt_mask_first_ff;
                default: reg_rdata_ff <= RST_ZERO;
            endcase
        end
    end

endmodule // metering_threshold_calibration_regs

// ---- testbench/cal_regs_properties.sv ----
`timescale 1ns/1ps
module cal_regs_properties
    import cal_regs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [23:0] reg_rdata_ff,
    // settings and flags
    input wire logic [11:0] comp_a_ff,
    input wire logic [23:0] creep_ff,
    input wire logic [23:0] peak_ff,
    input wire logic [23:0] quick_rms_ff,
    input wire logic [11:0] line_cycle_count_ff,
    input wire logic [GAIN_W-1:0] summed_current_rms_gain_ff,
    input wire logic [SHDN_W-1:0] channel_converter_shutdown_ff,
    input wire logic [23:0] user_mode_select_3_ff,
    input wire logic measure_reset_ff,
    input wire logic neutral_compare_flag_ff,
    input wire logic interrupt_request_first_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ---------------------------------------------------------------
    // sequences
    // ---------------------------------------------------------------
    sequence key_write(logic [23:0] k);
        reg_wr && reg_addr == ADDR_SOFTRST && reg_wdata == k;
    endsequence
    sequence one_pulse;
        measure_reset_ff ##1 !measure_reset_ff;
    endsequence
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    a_meas_key_pulse: assert property (key_write(KEY_MEAS) |=> one_pulse)
        else $error("measurement reset pulse wrong");
    a_cal_key_defaults: assert property (key_write(KEY_CAL) |=> creep_ff == RST_CREEP
        && peak_ff == RST_ONES && quick_rms_ff == RST_QUICK)
        else $error("calibration key left settings changed");
    a_rsvd_reads_default: assert property (reg_rd && reg_addr == ADDR_RSVD
        |=> reg_rdata_ff == RST_RSVD)
        else $error("reserved register read wrong");
    a_shdn_bits_kept: assert property (reg_wr && reg_addr == ADDR_SHDN
        |=> channel_converter_shutdown_ff == ($past(reg_wdata[SHDN_W-1:0]) & SHDN_MASK))
        else $error("shutdown register write wrong");
    a_line_cycles_write: assert property (reg_wr && reg_addr == ADDR_SAG_LC
        |=> line_cycle_count_ff == $past(reg_wdata[11:0]))
        else $error("line cycle count write wrong");
    a_gain_width_write: assert property (reg_wr && reg_addr == ADDR_SGAIN
        |=> summed_current_rms_gain_ff == $past(reg_wdata[GAIN_W-1:0]))
        else $error("gain write wrong");
    a_comp_a_write: assert property (reg_wr && reg_addr == ADDR_COMP_A
        |=> comp_a_ff == $past(reg_wdata[11:0]))
        else $error("compensation write wrong");
    a_creep_holds: assert property (!reg_wr |=> $stable(creep_ff))
        else $error("anti-creep register changed without a write");
    a_user_mode_select_3_readback: assert property (reg_rd && reg_addr == ADDR_USER_MODE_SELECT_3
        |=> reg_rdata_ff == $past(user_mode_select_3_ff))
        else $error("mode 3 read wrong");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b
        |=> !interrupt_request_first_ff && !neutral_compare_flag_ff)
        else $error("flags high after reset");
endmodule // cal_regs_properties

bind metering_threshold_calibration_regs cal_regs_properties cal_regs_properties_inst (.*);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import cal_regs_pkg::*;
;
    logic clk, rst_b, reg_wr, reg_rd, line_cycle_tick, zero_cross, sample_tick;
    logic [7:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata_ff, summed_current_rms, neutral_current_rms;
    logic [11:0] voltage_abs, comp_b_ff, comp_c_ff;
    logic [23:0] creep2_ff, rev_rms_ff, neutral_phase_calibration_ff;
    logic [23:0] summed_current_rms_offset_ff, user_mode_select_1_ff, user_mode_select_2_ff;
    logic measure_reset_ff, neutral_compare_flag_ff, interrupt_request_first_ff;
    int n_fail = 0;
    int tests_run = 0;
    // ---------------------------------------------------------------
    // clock and design
    // ---------------------------------------------------------------
    always #25 clk = ~clk;
    metering_threshold_calibration_regs metering_threshold_calibration_regs_inst (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .summed_current_rms(summed_current_rms), .neutral_current_rms(neutral_current_rms),
        .voltage_abs(voltage_abs), .line_cycle_tick(line_cycle_tick),
        .zero_cross(zero_cross), .sample_tick(sample_tick),
        .comp_a_ff(), .comp_b_ff(comp_b_ff), .comp_c_ff(comp_c_ff), .creep_ff(),
        .creep2_ff(creep2_ff), .rev_rms_ff(rev_rms_ff), .quick_rms_ff(), .peak_ff(),
        .line_cycle_count_ff(), .summed_current_rms_gain_ff(),
        .neutral_phase_calibration_ff(neutral_phase_calibration_ff),
        .summed_current_rms_offset_ff(summed_current_rms_offset_ff),
        .channel_converter_shutdown_ff(), .user_mode_select_1_ff(user_mode_select_1_ff), .user_mode_select_2_ff(user_mode_select_2_ff),
        .user_mode_select_3_ff(), .measure_reset_ff(measure_reset_ff),
        .neutral_compare_flag_ff(neutral_compare_flag_ff),
        .interrupt_request_first_ff(interrupt_request_first_ff));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task chk(input string n, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // data stands from the cycle after the read edge until the next read
    task rd(input logic [7:0] a, input logic [23:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, reg_rdata_ff);
    endtask
    function automatic logic [23:0] dflt(input logic [7:0] a);
        case (a)
            ADDR_CREEP: return RST_CREEP;
            ADDR_REV_RMS: return RST_REV_RMS;
            ADDR_QUICK: return RST_QUICK;
            ADDR_PEAK, ADDR_NCMP: return RST_ONES;
            ADDR_SAG_ZX: return RST_SAG_ZX;
            ADDR_SAG_LC: return RST_SAG_LC;
            ADDR_RSVD: return RST_RSVD;
            default: return 24'h00_0000;
        endcase
    endfunction
    // narrow registers read back only their own bits
    function automatic logic [23:0] wmask(input logic [7:0] a);
        case (a)
            ADDR_COMP_A, ADDR_COMP_B, ADDR_COMP_C: return 24'h00_0fff;
            ADDR_SGAIN: return 24'h00_ffff;
            ADDR_SHDN: return {13'h0, SHDN_MASK};
            ADDR_RSVD, 8'h95: return 24'h00_0000;
            default: return 24'hff_ffff;
        endcase
    endfunction
    task check_defaults;
        for (int a = 'h85; a <= 'h9a; a++) rd(8'(a), dflt(8'(a)));
    endtask
    task ticks(input int n, input logic zc);
        repeat (n) begin
            @(posedge clk);
            {sample_tick, line_cycle_tick, zero_cross} <= {2'b11, zc};
            @(posedge clk);
            {sample_tick, line_cycle_tick, zero_cross} <= 3'b000;
        end
        repeat (3) @(posedge clk);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // watchdog, far beyond the few hundred cycles the tests need
    // ---------------------------------------------------------------
    initial begin
        #2_000_000;
        n_fail++;
        finish_test;
    end
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        clk = 0;
        rst_b = 0;
        {reg_wr, reg_rd, line_cycle_tick, zero_cross, sample_tick} = 5'b0;
        reg_addr = 8'h00;
        reg_wdata = 24'h00_0000;
        summed_current_rms = 24'h00_0000;
        neutral_current_rms = 24'h00_0000;
        voltage_abs = 12'h000;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        check_defaults;
        $display("test reset_defaults done");
        for (int a = 'h85; a <= 'h9a; a++) begin
            if (a != 'h99) begin
                wr(8'(a), {8'(a), ~8'(a), 8'(a)});
                rd(8'(a), (a == 'h94) ? RST_RSVD : {8'(a), ~8'(a), 8'(a)} & wmask(8'(a)));
            end
        end
        chk("comp_b out", 24'(comp_b_ff), 24'h00_0986);
        chk("comp_c out", 24'(comp_c_ff), 24'h00_0887);
        chk("creep2 out", creep2_ff, 24'h89_7689);
        chk("rev_rms out", rev_rms_ff, 24'h8a_758a);
        chk("phcal out", neutral_phase_calibration_ff, 24'h90_6f90);
        chk("offset out", summed_current_rms_offset_ff, 24'h92_6d92);
        chk("user_mode_select_1 out", user_mode_select_1_ff, 24'h96_6996);
        chk("user_mode_select_2 out", user_mode_select_2_ff, 24'h97_6897);
        $display("test write_readback done");
        wr(ADDR_INTERRUPT_MASK_FIRST, 24'h00_0000);
        wr(ADDR_NCMP, 24'h00_1000);
        wr(ADDR_USER_MODE_SELECT_3, 24'h00_0010);
        rd(ADDR_STATUS, 24'h00_0000);
        neutral_current_rms <= 24'h00_1000;
        repeat (3) @(posedge clk);
        chk("flag at level", 24'(neutral_compare_flag_ff), 24'h1);
        neutral_current_rms <= 24'h00_0fff;
        repeat (3) @(posedge clk);
        chk("flag below", 24'(neutral_compare_flag_ff), 24'h0);
        wr(ADDR_USER_MODE_SELECT_3, 24'h00_0000);
        summed_current_rms <= 24'h00_2000;
        repeat (3) @(posedge clk);
        chk("flag summed", 24'(neutral_compare_flag_ff), 24'h1);
        chk("irq masked", 24'(interrupt_request_first_ff), 24'h0);
        wr(ADDR_INTERRUPT_MASK_FIRST, 24'h00_0001);
        repeat (3) @(posedge clk);
        chk("irq unmasked", 24'(interrupt_request_first_ff), 24'h1);
        summed_current_rms <= 24'h00_0000;
        repeat (3) @(posedge clk);
        rd(ADDR_STATUS, 24'h00_0001);
        rd(ADDR_STATUS, 24'h00_0000);
        repeat (3) @(posedge clk);
        chk("irq cleared", 24'(interrupt_request_first_ff), 24'h0);
        $display("test neutral_compare done");
        wr(ADDR_SAG_LC, RST_SAG_LC);
        wr(ADDR_SAG_ZX, 24'h02_0004);
        wr(ADDR_INTERRUPT_MASK_FIRST, 24'h00_0006);
        voltage_abs <= 12'hfff;
        ticks(6, 1'b1);
        rd(ADDR_STATUS, 24'h00_0000);
        voltage_abs <= 12'h0ff;
        ticks(6, 1'b0);
        chk("irq events", 24'(interrupt_request_first_ff), 24'h1);
        rd(ADDR_STATUS, 24'h00_0006);
        $display("test sag_timeout done");
        wr(ADDR_SOFTRST, KEY_MEAS);
        #1 chk("measure pulse", 24'(measure_reset_ff), 24'h1);
        rd(ADDR_INTERRUPT_MASK_FIRST, 24'h00_0006);
        wr(ADDR_SOFTRST, KEY_CAL);
        check_defaults;
        $display("test soft_reset done");
        finish_test;
    end
endmodule // tb_top
